// ### include/xcvr_pkg.sv
/*
 constants for the 18-bit two-way storage transceiver: bus map, field
 positions, reset values and the layout of the sampled pin vector.
 assumes the pins are asynchronous to clk_sys and sampled twice.
*/
//
// Function
// - carry 18 bits each way, no inversion
// - high latch enable makes storage transparent
// - latch low, clock steady: storage holds
// - latch low: capture on clock fall
// - clock rising edges capture nothing
// - latch enable falling freezes the input
// - a-to-b enable high drives side b; here only while CTRL_AB_ALLOW_BIT of the control register is set
// - a-to-b enable low floats side b
// - b-to-a path same, own controls
// - b-to-a enable active low
package xcvr_pkg;
	localparam int DATA_W = 18;
	localparam int ADDR_W = 5;

	localparam logic [4:0] CTRL_OFS = 5'h00;
	localparam logic [4:0] AB_STORE_OFS = 5'h04;
	localparam logic [4:0] BA_STORE_OFS = 5'h08;
	localparam logic [4:0] PIN_STATUS_OFS = 5'h0C;
	localparam logic [4:0] CAPT_CNT_OFS = 5'h10;

	localparam int CTRL_AB_ALLOW_BIT = 0;
	localparam int CTRL_BA_ALLOW_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;

	localparam int CNT_W = 16;
	localparam int CNT_BA_LSB = 16;

	localparam int PIN_AB_OE = 0;
	localparam int PIN_BA_OE_N = 1;
	localparam int PIN_AB_LE = 2;
	localparam int PIN_BA_LE = 3;
	localparam int PIN_AB_CLK = 4;
	localparam int PIN_BA_CLK = 5;
	localparam int PIN_CTRL_W = 6;
	localparam int PIN_A_LSB = 6;
	localparam int PIN_B_LSB = 24;
	localparam int PIN_W = 42;
	localparam logic [41:0] PIN_RESET = 42'h00000000002;
endpackage

// ### include/xcvr_dir_if.sv
/*
 one direction of the transceiver: sampled controls and data in,
 stored word and capture pulse out.
 assumes all inputs are already synchronised to clk_sys.
*/
`timescale 1ns/1ps
interface xcvr_dir_if;
	logic le;
	logic clk;
	logic [17:0] din;
	logic [17:0] store;
	logic capture;

	modport path (input le, input clk, input din, output store, output capture);
	modport ctrl (output le, output clk, output din, input store, input capture);
endinterface

// ### rtl/xcvr_path.sv
/*
 storage element of one direction: transparent, latched or clocked on
 the falling edge of the direction clock.
 assumes synchronised inputs; the output enable is handled outside.
*/
`timescale 1ns/1ps
module xcvr_path (
	input wire logic clk_sys,
	input wire logic sys_rst,
	xcvr_dir_if.path dir
);
	logic le_prev_reg;
	logic le_prev_next;
	logic clk_prev_reg;
	logic clk_prev_next;
	logic [17:0] store_reg;
	logic [17:0] store_next;
	logic capture_reg;
	logic capture_next;

	always_comb begin
		le_prev_next = dir.le;
		clk_prev_next = dir.clk;
		store_next = store_reg;
		capture_next = 1'b0;
		if (dir.le) begin
			store_next = dir.din;
		end else if (le_prev_reg) begin
			store_next = dir.din;
			capture_next = 1'b1;
		end else if (clk_prev_reg && !dir.clk) begin
			store_next = dir.din;
			capture_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			le_prev_reg <= 1'b0;
			clk_prev_reg <= 1'b0;
			store_reg <= '0;
			capture_reg <= 1'b0;
		end else begin
			le_prev_reg <= le_prev_next;
			clk_prev_reg <= clk_prev_next;
			store_reg <= store_next;
			capture_reg <= capture_next;
		end
	end

	assign dir.store = store_reg;
	assign dir.capture = capture_reg;
endmodule

// ### rtl/xcvr_top.sv
/*
 18-bit two-way storage transceiver with an avalon-mm register slave.
 assumes pins arrive asynchronously and are sampled twice; the bench
 resolves each data wire from the output and the active-low enable.
*/
`timescale 1ns/1ps
module xcvr_top (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic a_to_b_output_enable,
	input wire logic b_to_a_output_enable_n,
	input wire logic a_to_b_latch_enable,
	input wire logic b_to_a_latch_enable,
	input wire logic a_to_b_clock,
	input wire logic b_to_a_clock,
	input wire logic [17:0] side_a_data_in,
	output logic [17:0] side_a_data_out,
	output logic side_a_data_oe_n,
	input wire logic [17:0] side_b_data_in,
	output logic [17:0] side_b_data_out,
	output logic side_b_data_oe_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
		hit = (addr == ofs);
	endfunction

	// pin sampling: first stage feeds only the second
	logic [41:0] pin_raw;
	logic [41:0] meta_reg;
	logic [41:0] meta_next;
	logic [41:0] pin_reg;
	logic [41:0] pin_next;

	assign pin_raw = {side_b_data_in, side_a_data_in, b_to_a_clock, a_to_b_clock,
		b_to_a_latch_enable, a_to_b_latch_enable, b_to_a_output_enable_n, a_to_b_output_enable};

	always_comb begin
		meta_next = pin_raw;
		pin_next = meta_reg;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_reg <= xcvr_pkg::PIN_RESET;
			pin_reg <= xcvr_pkg::PIN_RESET;
		end else begin
			meta_reg <= meta_next;
			pin_reg <= pin_next;
		end
	end

	logic ab_oe_s;
	logic ba_oe_n_s;
	logic [17:0] a_din_s;
	logic [17:0] b_din_s;

	assign ab_oe_s = pin_reg[xcvr_pkg::PIN_AB_OE];
	assign ba_oe_n_s = pin_reg[xcvr_pkg::PIN_BA_OE_N];
	assign a_din_s = pin_reg[xcvr_pkg::PIN_A_LSB +: xcvr_pkg::DATA_W];
	assign b_din_s = pin_reg[xcvr_pkg::PIN_B_LSB +: xcvr_pkg::DATA_W];

	// two directions, same storage element
	xcvr_dir_if ab ();
	xcvr_dir_if ba ();

	assign ab.le = pin_reg[xcvr_pkg::PIN_AB_LE];
	assign ab.clk = pin_reg[xcvr_pkg::PIN_AB_CLK];
	assign ab.din = a_din_s;
	assign ba.le = pin_reg[xcvr_pkg::PIN_BA_LE];
	assign ba.clk = pin_reg[xcvr_pkg::PIN_BA_CLK];
	assign ba.din = b_din_s;

	xcvr_path u_ab (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.dir(ab)
	);

	xcvr_path u_ba (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.dir(ba)
	);

	// control register: software gates for each driver
	logic [1:0] ctrl_reg;
	logic [1:0] ctrl_next;

	logic ab_drive;
	logic ba_drive;

	assign ab_drive = ab_oe_s && ctrl_reg[xcvr_pkg::CTRL_AB_ALLOW_BIT];
	assign ba_drive = !ba_oe_n_s && ctrl_reg[xcvr_pkg::CTRL_BA_ALLOW_BIT];

	assign side_b_data_out = ab.store;
	assign side_b_data_oe_n = !ab_drive;
	assign side_a_data_out = ba.store;
	assign side_a_data_oe_n = !ba_drive;

	// capture counters, cleared by a write; a capture in the same cycle still counts one
	logic [15:0] ab_cnt_reg;
	logic [15:0] ab_cnt_next;
	logic [15:0] ba_cnt_reg;
	logic [15:0] ba_cnt_next;

	// bus slave: one wait cycle on every access
	logic ack_reg;
	logic ack_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic req;
	logic wr_take;
	logic [31:0] pin_status;

	assign req = avs_read || avs_write;
	assign wr_take = avs_write && ack_reg;
	assign avs_waitrequest = req && !ack_reg;
	assign avs_readdata = rdata_reg;
	assign pin_status = {26'h0000000, pin_reg[xcvr_pkg::PIN_CTRL_W-1:0]};

	always_comb begin
		ack_next = req && !ack_reg;
		rdata_next = rdata_reg;
		if (avs_read && !ack_reg) begin
			rdata_next = '0;
			if (hit(avs_address, xcvr_pkg::CTRL_OFS)) begin
				rdata_next = {30'h00000000, ctrl_reg};
			end else if (hit(avs_address, xcvr_pkg::AB_STORE_OFS)) begin
				rdata_next = {14'h0000, ab.store};
			end else if (hit(avs_address, xcvr_pkg::BA_STORE_OFS)) begin
				rdata_next = {14'h0000, ba.store};
			end else if (hit(avs_address, xcvr_pkg::PIN_STATUS_OFS)) begin
				rdata_next = pin_status;
			end else if (hit(avs_address, xcvr_pkg::CAPT_CNT_OFS)) begin
				rdata_next = {ba_cnt_reg, ab_cnt_reg};
			end
		end
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		ab_cnt_next = ab_cnt_reg + 16'h0001 * ab.capture;
		ba_cnt_next = ba_cnt_reg + 16'h0001 * ba.capture;
		if (wr_take && hit(avs_address, xcvr_pkg::CTRL_OFS) && avs_byteenable[0]) begin
			ctrl_next = avs_writedata[1:0];
		end
		if (wr_take && hit(avs_address, xcvr_pkg::CAPT_CNT_OFS)) begin
			if (avs_byteenable[0] || avs_byteenable[1]) begin
				ab_cnt_next = 16'h0000 + 16'h0001 * ab.capture;
			end
			if (avs_byteenable[2] || avs_byteenable[3]) begin
				ba_cnt_next = 16'h0000 + 16'h0001 * ba.capture;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ack_reg <= 1'b0;
			rdata_reg <= '0;
			ctrl_reg <= xcvr_pkg::CTRL_RESET;
			ab_cnt_reg <= '0;
			ba_cnt_reg <= '0;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			ab_cnt_reg <= ab_cnt_next;
			ba_cnt_reg <= ba_cnt_next;
		end
	end

	// checks on the storage paths, drivers and bus slave
	transparent_ab_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ab.le |=> ab.store == $past(a_din_s))
		else $error("a-to-b storage not transparent");

	noninvert_ab_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ab.le && ab_drive ##1 ab_drive |-> side_b_data_out == $past(a_din_s))
		else $error("side b does not follow side a");

	hold_ab_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ab.le && !$past(ab.le) && !($past(ab.clk) && !ab.clk) |=> $stable(ab.store))
		else $error("a-to-b storage changed while held");

	clock_fall_ab_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ab.le && !$past(ab.le) && $past(ab.clk) && !ab.clk
		|=> ab.store == $past(a_din_s) && ab.capture)
		else $error("a-to-b clock fall did not capture");

	clock_rise_ab_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ab.le && !$past(ab.le) && $rose(ab.clk) |=> $stable(ab.store) && !ab.capture)
		else $error("a-to-b clock rise captured data");

	latch_fall_ab_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(ab.le) |=> ab.store == $past(a_din_s) ##1 ($past(ab.le) || $past(ab.clk, 2) && !$past(ab.clk)
		|| $stable(ab.store)))
		else $error("a-to-b latch fall did not freeze input");

	drive_b_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ab_oe_s && ctrl_reg[xcvr_pkg::CTRL_AB_ALLOW_BIT]
		|-> !side_b_data_oe_n && side_b_data_out == ab.store)
		else $error("side b not driven from storage");

	float_b_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ab_oe_s |-> side_b_data_oe_n)
		else $error("side b driven while disabled");

	path_ba_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ba.le || !$past(ba.le) && $past(ba.clk) && !ba.clk) |=> ba.store == $past(b_din_s))
		else $error("b-to-a storage missed input");

	polarity_ba_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ba_oe_n_s |-> side_a_data_oe_n ##0 (ba_oe_n_s || !ctrl_reg[xcvr_pkg::CTRL_BA_ALLOW_BIT]
		|| !side_a_data_oe_n))
		else $error("b-to-a enable polarity wrong");

	drive_a_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ba_oe_n_s && ctrl_reg[xcvr_pkg::CTRL_BA_ALLOW_BIT]
		|-> !side_a_data_oe_n && side_a_data_out == ba.store)
		else $error("side a not driven while enable low");

	store_offline_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ab_oe_s && !ab.le && !$past(ab.le) && $past(ab.clk) && !ab.clk
		|=> ab.store == $past(a_din_s) && ab.capture ##0 side_b_data_out == ab.store)
		else $error("storage stalled while outputs floated");

	bus_answer_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		req && !ack_reg |=> !avs_waitrequest)
		else $error("register access not answered in one wait cycle");
endmodule

// ### tb/xcvr_far_side.sv
/*
 model of the outside logic on both data buses: drives a side only while
 the device leaves it floating, otherwise resolves the wire from the device.
 assumes the bench says when and what each outside driver offers.
*/
`timescale 1ns/1ps
module xcvr_far_side (
	input wire logic clk_sys,
	input wire logic a_drive,
	input wire logic [17:0] a_val,
	input wire logic b_drive,
	input wire logic [17:0] b_val,
	input wire logic [17:0] dev_a,
	input wire logic dev_a_oe_n,
	input wire logic [17:0] dev_b,
	input wire logic dev_b_oe_n,
	output logic [17:0] side_a_wire,
	output logic [17:0] side_b_wire
);
	logic [17:0] a_last_reg = 18'h00000;
	logic [17:0] b_last_reg = 18'h00000;

	// an undriven wire keeps moving so a stale value is never mistaken for data
	always @(posedge clk_sys) begin
		a_last_reg <= side_a_wire;
		b_last_reg <= side_b_wire;
	end

	always_comb begin
		side_a_wire = ~a_last_reg;
		side_b_wire = ~b_last_reg;
		if (!dev_a_oe_n) begin
			side_a_wire = dev_a;
		end else if (a_drive) begin
			side_a_wire = a_val;
		end
		if (!dev_b_oe_n) begin
			side_b_wire = dev_b;
		end else if (b_drive) begin
			side_b_wire = b_val;
		end
	end
endmodule

// ### tb/universal_bus_transceiver_tb.sv
/*
 self-checking bench for the transceiver: pins driven directly, registers
 read over avalon-mm. assumes the 2-edge pin sampling of the design.
*/
`timescale 1ns/1ps
module universal_bus_transceiver_tb;
	logic clk_sys = 1'b0, sys_rst = 1'b1;
	logic ab_oe = 1'b0, ba_oe_n = 1'b1, ab_le = 1'b0, ba_le = 1'b0, ab_ck = 1'b0, ba_ck = 1'b0;
	logic a_drv = 1'b0, b_drv = 1'b0;
	logic [17:0] a_val = 18'h00000, b_val = 18'h00000, a_wire, b_wire, a_out, b_out;
	logic a_oe_n, b_oe_n, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h00000000, avs_readdata, rd;
	int fail_count = 0, num_checks = 0;

	initial forever #10 clk_sys = ~clk_sys;

	xcvr_top u_xcvr_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .a_to_b_output_enable(ab_oe),
		.b_to_a_output_enable_n(ba_oe_n), .a_to_b_latch_enable(ab_le), .b_to_a_latch_enable(ba_le),
		.a_to_b_clock(ab_ck), .b_to_a_clock(ba_ck), .side_a_data_in(a_wire), .side_a_data_out(a_out),
		.side_a_data_oe_n(a_oe_n), .side_b_data_in(b_wire), .side_b_data_out(b_out),
		.side_b_data_oe_n(b_oe_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));

	xcvr_far_side u_xcvr_far_side (.clk_sys(clk_sys), .a_drive(a_drv), .a_val(a_val), .b_drive(b_drv),
		.b_val(b_val), .dev_a(a_out), .dev_a_oe_n(a_oe_n), .dev_b(b_out), .dev_b_oe_n(b_oe_n),
		.side_a_wire(a_wire), .side_b_wire(b_wire));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// one avalon access; request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= adr;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk("bus edges", n, 32'h2);
	endtask

	// pins need 3 edges to reach the outputs; 6 leaves margin
	task automatic settle();
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end

	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		settle();
		chk("b oe_n reset", b_oe_n, 1'b1);
		chk("a oe_n reset", a_oe_n, 1'b1);
		bus(1'b0, xcvr_pkg::CTRL_OFS, 32'h0);
		chk("ctrl reset", rd, 32'h3);
		@(posedge clk_sys);
		a_drv <= 1'b1;
		a_val <= 18'h2A5C3;
		ab_le <= 1'b1;
		ab_oe <= 1'b1;
		settle();
		chk("b transparent", b_wire, 18'h2A5C3);
		chk("b oe_n on", b_oe_n, 1'b0);
		@(posedge clk_sys);
		ab_le <= 1'b0;
		settle();
		@(posedge clk_sys);
		a_val <= 18'h15A3C;
		settle();
		chk("b latched", b_wire, 18'h2A5C3);
		@(posedge clk_sys);
		ab_ck <= 1'b1;
		settle();
		chk("b after rise", b_wire, 18'h2A5C3);
		@(posedge clk_sys);
		ab_ck <= 1'b0;
		settle();
		chk("b clocked", b_wire, 18'h15A3C);
		@(posedge clk_sys);
		ab_oe <= 1'b0;
		a_val <= 18'h3FFFF;
		settle();
		chk("b oe_n off", b_oe_n, 1'b1);
		@(posedge clk_sys);
		ab_ck <= 1'b1;
		settle();
		@(posedge clk_sys);
		ab_ck <= 1'b0;
		settle();
		@(posedge clk_sys);
		ab_oe <= 1'b1;
		settle();
		chk("b after float", b_wire, 18'h3FFFF);
		@(posedge clk_sys);
		ab_oe <= 1'b0;
		a_drv <= 1'b0;
		b_drv <= 1'b1;
		b_val <= 18'h0F0F1;
		ba_le <= 1'b1;
		settle();
		chk("a oe_n high pin", a_oe_n, 1'b1);
		bus(1'b0, xcvr_pkg::PIN_STATUS_OFS, 32'h0);
		chk("pin status", rd, 32'hA);
		@(posedge clk_sys);
		ba_oe_n <= 1'b0;
		settle();
		chk("a transparent", a_wire, 18'h0F0F1);
		@(posedge clk_sys);
		ba_le <= 1'b0;
		settle();
		@(posedge clk_sys);
		b_val <= 18'h30F0E;
		ba_ck <= 1'b1;
		settle();
		chk("a held", a_wire, 18'h0F0F1);
		@(posedge clk_sys);
		ba_ck <= 1'b0;
		settle();
		chk("a clocked", a_wire, 18'h30F0E);
		bus(1'b0, xcvr_pkg::BA_STORE_OFS, 32'h0);
		chk("ba store", rd, 32'h30F0E);
		bus(1'b0, xcvr_pkg::AB_STORE_OFS, 32'h0);
		chk("ab store", rd, 32'h3FFFF);
		bus(1'b0, xcvr_pkg::CAPT_CNT_OFS, 32'h0);
		chk("captures", rd, 32'h00020003);
		bus(1'b1, xcvr_pkg::CTRL_OFS, 32'h0);
		settle();
		chk("a oe_n ctrl off", a_oe_n, 1'b1);
		bus(1'b1, xcvr_pkg::CTRL_OFS, 32'h3);
		bus(1'b1, xcvr_pkg::CAPT_CNT_OFS, 32'h0);
		bus(1'b0, xcvr_pkg::CAPT_CNT_OFS, 32'h0);
		chk("captures cleared", rd, 32'h0);
		bus(1'b0, 5'h1C, 32'h0);
		chk("unmapped", rd, 32'h0);
		settle();
		chk("a oe_n ctrl on", a_oe_n, 1'b0);
		wrap_up();
	end
endmodule
